// File: core/fdpi_pkg.sv
// Types for the floppy drive pin interface
package fdpi_pkg;
    typedef enum logic [1:0] {
        FDPI_ST_IDLE  = 2'b00,
        FDPI_ST_SETUP = 2'b01,
        FDPI_ST_PULSE = 2'b10,
        FDPI_ST_HOLD  = 2'b11
    } fdpi_step_st_t;
endpackage

// File: core/fdpi_regs.svh
// Constants for the floppy drive pin interface
`ifndef FDPI_REGS_SVH
`define FDPI_REGS_SVH

`define FDPI_CFG_PULLUP_DIS_BIT  7
`define FDPI_CFG_RESET           8'h00
`define FDPI_STEP_LOW_NS         3000
`define FDPI_STEP_SETUP_NS       1000
`define FDPI_CLK_NS              8
`define FDPI_STEP_LOW_CYC        ((`FDPI_STEP_LOW_NS + `FDPI_CLK_NS - 1) / `FDPI_CLK_NS)
`define FDPI_STEP_SETUP_CYC      ((`FDPI_STEP_SETUP_NS + `FDPI_CLK_NS - 1) / `FDPI_CLK_NS)
`define FDPI_CNT_W               10

`endif

// File: core/fdpi_step.sv
// Step pulse sequencer with direction held around each pulse
`timescale 1ns/1ps
`include "fdpi_regs.svh"
module fdpi_step (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_step_req,
    input  wire logic i_dir_out,
    output logic      o_step_ready,
    output logic      o_step_n,
    output logic      o_dir
);
    fdpi_pkg::fdpi_step_st_t           st_q;
    fdpi_pkg::fdpi_step_st_t           st_d;
    logic [`FDPI_CNT_W-1:0]            cnt_q;
    logic [`FDPI_CNT_W-1:0]            cnt_d;
    logic                              dir_q;
    logic                              step_n_q;
    wire                               cnt_done = (cnt_q == '0);
    wire                               take     = (st_q == fdpi_pkg::FDPI_ST_IDLE) && i_step_req;
    localparam logic [`FDPI_CNT_W-1:0] SETUP_N  = `FDPI_CNT_W'(`FDPI_STEP_SETUP_CYC - 1);
    localparam logic [`FDPI_CNT_W-1:0] LOW_N    = `FDPI_CNT_W'(`FDPI_STEP_LOW_CYC - 1);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        case (st_q)
            fdpi_pkg::FDPI_ST_IDLE: begin
                if (i_step_req) begin
                    st_d  = fdpi_pkg::FDPI_ST_SETUP;
                    cnt_d = SETUP_N;
                end
            end
            fdpi_pkg::FDPI_ST_SETUP: begin
                if (cnt_done) begin
                    st_d  = fdpi_pkg::FDPI_ST_PULSE;
                    cnt_d = LOW_N;
                end
            end
            fdpi_pkg::FDPI_ST_PULSE: begin
                if (cnt_done) begin
                    st_d  = fdpi_pkg::FDPI_ST_HOLD;
                    cnt_d = SETUP_N;
                end
            end
            fdpi_pkg::FDPI_ST_HOLD: begin
                if (cnt_done) begin
                    st_d = fdpi_pkg::FDPI_ST_IDLE;
                end
            end
            default: st_d = fdpi_pkg::FDPI_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q     <= fdpi_pkg::FDPI_ST_IDLE;
            cnt_q    <= '0;
            dir_q    <= 1'b1;
            step_n_q <= 1'b1;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            // [R16] direction latched per step
            if (take) begin
                dir_q <= i_dir_out;
            end
            // [R6] one low pulse per step
            step_n_q <= (st_d != fdpi_pkg::FDPI_ST_PULSE);
        end
    end

    assign o_step_ready = (st_q == fdpi_pkg::FDPI_ST_IDLE);
    assign o_step_n     = step_n_q;
    assign o_dir        = dir_q;
endmodule

// File: core/fdpi_sync.sv
// Two-flop synchroniser for drive status inputs
`timescale 1ns/1ps
module fdpi_sync #(
    parameter int W = 5
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Inactive drive lines idle high
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// File: core/fdpi_top.sv
// Drive-side pin interface of the floppy controller
// Summary of operation
// [R1] Motor A output low runs drive 0
// [R2] Motor B output low runs drive 1
// [R3] Select A open-drain, low enables drive A
// [R4] Select B open-drain, low enables drive B
// [R5] Direction high outward, low inward
// [R6] One low step pulse per track
// [R7] Head select high side 0, low side 1
// [R8] Precompensated write data low to drive
// [R9] Drive pulls index low at track start
// [R10] Drive pulls outer cylinder low at track 0
// [R11] Drive holds write protect low when protected
// [R12] Drive asserts media swap low on change
// [R13] Drive delivers raw read data stream
// [R14] 1k pull-ups, removed by config bit 7
// [R15] 24 or 48 MHz reference, 24 default
// [R16] Direction stable across each step pulse
// [R17] No write gate while write protected
`timescale 1ns/1ps
`include "fdpi_regs.svh"
module fdpi_top (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // Controller side
    input  wire logic       i_motor_a,
    input  wire logic       i_motor_b,
    input  wire logic       i_sel_a,
    input  wire logic       i_sel_b,
    input  wire logic       i_step_req,
    input  wire logic       i_dir_out,
    input  wire logic       i_side1,
    input  wire logic       i_wr_gate,
    input  wire logic       i_wr_data,
    input  wire logic [7:0] i_fdc_cfg_f0,
    input  wire logic       i_ref_48m,
    output logic            o_step_ready,
    output logic            o_index,
    output logic            o_outer_cylinder,
    output logic            o_write_protect,
    output logic            o_media_swap,
    output logic            o_read_data,
    output logic            o_ref_48m_sel,
    // Drive pins (open drain: _oe high pulls low)
    output logic            o_motor_a_on_n_oe,
    output logic            o_motor_b_on_n_oe,
    output logic            o_select_a_n_oe,
    output logic            o_select_b_n_oe,
    output logic            o_dir_n_oe,
    output logic            o_step_n_oe,
    output logic            o_head_n_oe,
    output logic            o_write_serial_n_oe,
    output logic            o_write_gate_n_oe,
    output logic            o_pullup_en,
    input  wire logic       i_index_n,
    input  wire logic       i_outer_cylinder_n,
    input  wire logic       i_write_protect_n,
    input  wire logic       i_read_data_n,
    input  wire logic       i_media_swap_n
);
    logic [4:0] pins_s;
    logic       step_n;
    logic       dir;
    logic [8:0] drv_q;
    logic       ref_q;
    logic       pu_q;

    fdpi_sync #(
        .W (5)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_index_n, i_outer_cylinder_n, i_write_protect_n, i_read_data_n, i_media_swap_n}),
        .o_sync    (pins_s)
    );

    fdpi_step u_step (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_step_req   (i_step_req),
        .i_dir_out    (i_dir_out),
        .o_step_ready (o_step_ready),
        .o_step_n     (step_n),
        .o_dir        (dir)
    );

    // [R9] index seen low at track start
    assign o_index          = ~pins_s[4];
    // [R10] outer cylinder indication
    assign o_outer_cylinder = ~pins_s[3];
    // [R11] protected diskette indication
    assign o_write_protect  = ~pins_s[2];
    // [R13] raw read stream, active high inside
    assign o_read_data      = ~pins_s[1];
    // [R12] media change indication
    assign o_media_swap     = ~pins_s[0];

    // [R17] write gate blocked by protect
    wire wr_ok = i_wr_gate & pins_s[2];

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            drv_q <= '0;
            ref_q <= 1'b0;
            pu_q  <= 1'b1;
        end else begin
            // [R1] [R2] [R3] [R4] motors and selects
            drv_q[0] <= i_motor_a;
            drv_q[1] <= i_motor_b;
            drv_q[2] <= i_sel_a;
            drv_q[3] <= i_sel_b;
            // [R5] low level means inward
            drv_q[4] <= ~dir;
            drv_q[5] <= ~step_n;
            // [R7] pulling low selects side 1
            drv_q[6] <= i_side1;
            // [R8] write data only with gate open
            drv_q[7] <= wr_ok & i_wr_data;
            drv_q[8] <= wr_ok;
            // [R14] pull-ups off when bit set
            pu_q  <= ~i_fdc_cfg_f0[`FDPI_CFG_PULLUP_DIS_BIT];
            // [R15] reference selection, 24 MHz default
            ref_q <= i_ref_48m;
        end
    end

    assign o_motor_a_on_n_oe   = drv_q[0];
    assign o_motor_b_on_n_oe   = drv_q[1];
    assign o_select_a_n_oe     = drv_q[2];
    assign o_select_b_n_oe     = drv_q[3];
    assign o_dir_n_oe          = drv_q[4];
    assign o_step_n_oe         = drv_q[5];
    assign o_head_n_oe         = drv_q[6];
    assign o_write_serial_n_oe = drv_q[7];
    assign o_write_gate_n_oe   = drv_q[8];
    assign o_pullup_en         = pu_q;
    assign o_ref_48m_sel       = ref_q;
endmodule

// File: verification/fdpi_drive_model.sv
// Behavioural floppy drive on the far side of the pins
`timescale 1ns/1ps
module fdpi_drive_model (
    input  wire logic       i_clk, i_pullup_en, i_step_n_oe, i_dir_n_oe,
    input  wire logic [3:0] i_drv,
    output logic      [4:0] o_pins
);
    logic [4:0] act;
    logic [7:0] trk = 8'h00;
    logic       stp = 1'b0;
    assign act = {i_drv[3], trk == 8'h00, i_drv[2:0]};
    initial o_pins = 5'h1F;
    always @(posedge i_clk) begin
        stp <= i_step_n_oe;
        if (i_step_n_oe && !stp) trk <= i_dir_n_oe ? trk + 8'h01 : (trk == 8'h00 ? trk : trk - 8'h01);
        // Released line without pull-up wanders
        for (int k = 0; k < 5; k++) o_pins[k] <= act[k] ? 1'b0 : (i_pullup_en ? 1'b1 : ~o_pins[k]);
    end
endmodule

// File: verification/fdpi_top_sva.sv
// Port assertions for the drive pin interface
`timescale 1ns/1ps
module fdpi_top_sva (
    input wire logic       i_clk, i_sys_rst, i_motor_a, i_motor_b, i_sel_a, i_sel_b, i_side1, i_dir_out,
    input wire logic [7:0] i_fdc_cfg_f0,
    input wire logic       o_step_ready, o_write_protect, o_motor_a_on_n_oe, o_motor_b_on_n_oe,
    input wire logic       o_select_a_n_oe, o_select_b_n_oe, o_dir_n_oe, o_step_n_oe, o_head_n_oe,
    input wire logic       o_write_gate_n_oe, o_pullup_en
);
    logic live_q;
    always_ff @(posedge i_clk) begin
        live_q <= !i_sys_rst;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    AST_MOTOR_A: assert property (live_q |-> o_motor_a_on_n_oe == $past(i_motor_a)) else $error("motor a");
    AST_MOTOR_B: assert property (live_q |-> o_motor_b_on_n_oe == $past(i_motor_b)) else $error("motor b");
    AST_SEL_A: assert property (live_q |-> o_select_a_n_oe == $past(i_sel_a)) else $error("select a");
    AST_SEL_B: assert property (live_q |-> o_select_b_n_oe == $past(i_sel_b)) else $error("select b");
    AST_HEAD: assert property (live_q |-> o_head_n_oe == $past(i_side1)) else $error("head select");
    AST_PULLUP: assert property (live_q |-> o_pullup_en == !$past(i_fdc_cfg_f0[7])) else $error("pullup");
    AST_NO_WRITE: assert property ($past(o_write_protect) |-> !o_write_gate_n_oe) else $error("gate");
    AST_DIR: assert property ($fell(o_step_ready) |-> ##2 o_dir_n_oe == !$past(i_dir_out, 3)) else $error("dir");
    AST_DIR_HOLD: assert property (o_step_n_oe |-> $stable(o_dir_n_oe)) else $error("dir moved");
    AST_STEP_START: assert property ($fell(o_step_ready) |-> ##[100:140] o_step_n_oe) else $error("no step");
    AST_STEP_WIDTH: assert property ($rose(o_step_n_oe) |-> ##[370:380] $fell(o_step_n_oe)) else $error("width");
endmodule

// File: verification/test_fdpi_top.sv
// Self-checking bench for the drive pin interface
`timescale 1ns/1ps
module test_fdpi_top;
    logic i_clk = 0, i_sys_rst = 1, i_motor_a = 0, i_motor_b = 0, i_sel_a = 0, i_sel_b = 0, i_step_req = 0;
    logic i_dir_out = 0, i_side1 = 0, i_wr_gate = 0, i_wr_data = 0, i_ref_48m = 0;
    logic [7:0] i_fdc_cfg_f0 = 8'h00;
    logic [3:0] drv = 4'h0;
    wire  [4:0] pins;
    wire o_step_ready, o_index, o_outer_cylinder, o_write_protect, o_media_swap, o_read_data, o_ref_48m_sel;
    wire o_motor_a_on_n_oe, o_motor_b_on_n_oe, o_select_a_n_oe, o_select_b_n_oe, o_dir_n_oe, o_step_n_oe;
    wire o_head_n_oe, o_write_serial_n_oe, o_write_gate_n_oe, o_pullup_en;
    wire [7:0] oes = {1'b0, o_motor_a_on_n_oe, o_motor_b_on_n_oe, o_select_a_n_oe, o_select_b_n_oe,
                      o_head_n_oe, o_write_gate_n_oe, o_write_serial_n_oe};
    wire [7:0] stat = {3'b0, o_index, o_outer_cylinder, o_write_protect, o_read_data, o_media_swap};
    logic [7:0] rows [5] = '{8'hAE, 8'h57, 8'hFD, 8'h06, 8'h02};
    int fails = 0, checks = 0;
    fdpi_top DUT (.i_clk, .i_sys_rst, .i_motor_a, .i_motor_b, .i_sel_a, .i_sel_b, .i_step_req, .i_dir_out,
        .i_side1, .i_wr_gate, .i_wr_data, .i_fdc_cfg_f0, .i_ref_48m, .o_step_ready, .o_index,
        .o_outer_cylinder, .o_write_protect, .o_media_swap, .o_read_data, .o_ref_48m_sel,
        .o_motor_a_on_n_oe, .o_motor_b_on_n_oe, .o_select_a_n_oe, .o_select_b_n_oe, .o_dir_n_oe,
        .o_step_n_oe, .o_head_n_oe, .o_write_serial_n_oe, .o_write_gate_n_oe, .o_pullup_en,
        .i_index_n(pins[4]), .i_outer_cylinder_n(pins[3]), .i_write_protect_n(pins[2]),
        .i_read_data_n(pins[1]), .i_media_swap_n(pins[0]));
    fdpi_drive_model u_drive (.i_clk, .i_pullup_en(o_pullup_en), .i_step_n_oe(o_step_n_oe),
        .i_dir_n_oe(o_dir_n_oe), .i_drv(drv), .o_pins(pins));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Request held three cycles, extra cycles refused
    task automatic step(input logic d);
        i_dir_out = d;
        i_step_req = 1;
        repeat (3) @(negedge i_clk);
        i_step_req = 0;
        i_dir_out = !d;
        for (int n = 0; n < 800 && o_step_ready !== 1'b1; n++) @(negedge i_clk);
        chk("ready", 8'h01, {7'b0, o_step_ready});
        chk("dir_oe", {7'b0, !d}, {7'b0, o_dir_n_oe});
        repeat (4) @(negedge i_clk);
    endtask
    initial forever #4 i_clk = ~i_clk;
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        results();
    end
    initial begin
        repeat (16) @(negedge i_clk);
        chk("rst_oe", 8'h00, oes);
        chk("rst_cfg", 8'h03, {6'b0, o_pullup_en, o_step_ready});
        chk("rst_ref", 8'h00, {7'b0, o_ref_48m_sel});
        i_sys_rst = 0;
        foreach (rows[k]) begin
            {i_motor_a, i_motor_b, i_sel_a, i_sel_b, i_side1, i_wr_gate, i_wr_data} = rows[k][7:1];
            drv = {rows[k][7], rows[k][0], rows[k][1], rows[k][6]};
            repeat (5) @(negedge i_clk);
            chk("pin_oe", {1'b0, rows[k][7:3], rows[k][2] & !rows[k][0], &rows[k][2:1] & !rows[k][0]}, oes);
            chk("status", {3'b0, rows[k][7], 1'b1, rows[k][0], rows[k][1], rows[k][6]}, stat);
        end
        drv = 4'h0;
        step(1'b0);
        chk("inward", 8'h00, stat);
        step(1'b1);
        chk("outward", 8'h08, stat);
        i_fdc_cfg_f0 = 8'h80;
        i_ref_48m = 1;
        repeat (2) @(negedge i_clk);
        chk("pullup", 8'h00, {7'b0, o_pullup_en});
        chk("ref_sel", 8'h01, {7'b0, o_ref_48m_sel});
        i_sys_rst = 1;
        repeat (2) @(negedge i_clk);
        chk("mid_oe", 8'h00, oes);
        chk("mid_cfg", 8'h03, {6'b0, o_pullup_en, o_step_ready});
        chk("mid_ref", 8'h00, {7'b0, o_ref_48m_sel});
        i_sys_rst = 0;
        repeat (2) @(negedge i_clk);
        chk("rel_cfg", 8'h01, {6'b0, o_pullup_en, o_step_ready});
        chk("rel_ref", 8'h01, {7'b0, o_ref_48m_sel});
        results();
    end
endmodule
bind fdpi_top fdpi_top_sva u_sva (.i_clk, .i_sys_rst, .i_motor_a, .i_motor_b, .i_sel_a, .i_sel_b, .i_side1,
    .i_dir_out, .i_fdc_cfg_f0, .o_step_ready, .o_write_protect, .o_motor_a_on_n_oe, .o_motor_b_on_n_oe,
    .o_select_a_n_oe, .o_select_b_n_oe, .o_dir_n_oe, .o_step_n_oe, .o_head_n_oe, .o_write_gate_n_oe, .o_pullup_en);
